// file: hw/adc_cfg_consts.svh
// offsets, field positions, reset values and counts of the config bank
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------
`define IDX_AMP_GAIN_SETTING 8'h03
`define IDX_CONV_RATE_CONFIG 8'h04
`define IDX_BIAS_SOURCE_CFG 8'h05
`define ADDR_AMP_GAIN_SETTING (`IDX_AMP_GAIN_SETTING * 4)
`define ADDR_CONV_RATE_CONFIG (`IDX_CONV_RATE_CONFIG * 4)
`define ADDR_BIAS_SOURCE_CFG (`IDX_BIAS_SOURCE_CFG * 4)

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_AMP_GAIN_SETTING 8'h00
`define RST_CONV_RATE_CONFIG 8'h14
`define RST_BIAS_SOURCE_CFG 8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DELAY_MSB 7
`define DELAY_LSB 5
`define AMP_EN_MSB 4
`define AMP_EN_LSB 3
`define GAIN_MSB 2
`define GAIN_LSB 0
`define CHOP_BIT 7
`define CLK_SRC_BIT 6
`define MODE_BIT 5
`define FILTER_BIT 4
`define RATE_MSB 3
`define RATE_LSB 0

// ----------------------------------------------------------------------
// field codes
// ----------------------------------------------------------------------
`define AMP_EN_BYPASS 2'h0
`define AMP_EN_ACTIVE 2'h1

// ----------------------------------------------------------------------
// first conversion delay, in modulator periods
// ----------------------------------------------------------------------
`define DLY_CODE0 12'h00E
`define DLY_CODE1 12'h019
`define DLY_CODE2 12'h040
`define DLY_CODE3 12'h100
`define DLY_CODE4 12'h400
`define DLY_CODE5 12'h800
`define DLY_CODE7 12'h001

`endif

// file: hw/adc_cfg_pkg.sv
// types shared by the converter configuration bank
package adc_cfg_pkg;

   // ----------------------------------------------------------------------
   // conversion sequencer states, one-hot
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_SETTLE = 3'b010,
      SEQ_RUN = 3'b100
   } seq_state_t;

endpackage

// file: hw/adc_gain_rate_config_regs.sv
// gain and data rate configuration bank with apb slave and start sequencer
//
// What this block does
// - delay code picks first conversion wait
// - delay applies after config restart or start request
// - amp enable code bypasses or enables amplifier
// - gain code gives two to power code
// - chop swaps polarity, flags every second reading for pair averaging
// - clock bit picks internal or external
// - mode bit picks continuous or single-shot
// - filter bit picks sinc3 or low-latency
// - rate code maps to output data rate
// - gain register at 03h, resets 00h
// - rate register at 04h, resets 14h
// - reference register at 05h, resets 10h
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.svh"

module adc_gain_rate_config_regs (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mod_tick,
   input wire logic start_req,
   input wire logic conv_done,
   output logic conv_start,
   output logic filter_reset,
   output logic amp_powered,
   output logic amp_cfg_reserved,
   output logic [7:0] gain_mult,
   output logic chop_enable,
   output logic chop_swap,
   output logic chop_avg_ready,
   output logic clk_src_ext,
   output logic single_shot,
   output logic filter_sinc3,
   output logic [15:0] rate_sps_x10,
   output logic rate_valid,
   output logic [7:0] bias_cfg
);

   // ----------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------

   // first conversion wait for a delay code, in modulator periods
   function automatic logic [11:0] delay_periods(input logic [2:0] code);
      logic [11:0] p;
      p = `DLY_CODE0;
      case (code)
         3'h0: p = `DLY_CODE0;
         3'h1: p = `DLY_CODE1;
         3'h2: p = `DLY_CODE2;
         3'h3: p = `DLY_CODE3;
         3'h4: p = `DLY_CODE4;
         3'h5: p = `DLY_CODE5;
         3'h7: p = `DLY_CODE7;
         default: p = `DLY_CODE0; // undefined code falls back to default
      endcase
      return p;
   endfunction

   // output data rate in tenths of a sample per second, zero if undefined
   function automatic logic [15:0] rate_of(input logic [3:0] code);
      logic [15:0] r;
      r = 16'h0000;
      case (code)
         4'h0: r = 16'h0019;
         4'h1: r = 16'h0032;
         4'h2: r = 16'h0064;
         4'h3: r = 16'h00A6;
         4'h4: r = 16'h00C8;
         4'h5: r = 16'h01F4;
         4'h6: r = 16'h0258;
         4'h7: r = 16'h03E8;
         4'h8: r = 16'h07D0;
         4'h9: r = 16'h0FA0;
         4'hA: r = 16'h1F40;
         4'hB: r = 16'h2710;
         4'hE: r = 16'h4E20;
         default: r = 16'h0000;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // storage and bus signals
   // ----------------------------------------------------------------------
   logic [7:0] amp_gain_setting_r;
   logic [7:0] conv_rate_config_r;
   logic [7:0] bias_source_config_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic setup_phase;
   logic wr_take;
   logic hit_gain;
   logic hit_rate;
   logic hit_bias;
   logic hit_any;
   logic [7:0] wbyte;
   logic cfg_change;

   assign setup_phase = psel & ~penable;
   assign wr_take = psel & penable & pwrite & pready_r;
   assign hit_gain = (paddr == 8'(`ADDR_AMP_GAIN_SETTING));
   assign hit_rate = (paddr == 8'(`ADDR_CONV_RATE_CONFIG));
   assign hit_bias = (paddr == 8'(`ADDR_BIAS_SOURCE_CFG));
   assign hit_any = hit_gain | hit_rate | hit_bias;
   assign wbyte = pwdata[7:0];

   // a write counts as a configuration change when the stored byte moves
   assign cfg_change = wr_take & ((hit_gain & (wbyte != amp_gain_setting_r)) |
      (hit_rate & (wbyte != conv_rate_config_r)) |
      (hit_bias & (wbyte != bias_source_config_r)));

   // ----------------------------------------------------------------------
   // apb handshake: answer in the first access cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup_phase;
         pslverr_r <= setup_phase & ~hit_any; // unmapped address errors
      end
   end

   // read data captured in the setup cycle, narrow data in low bits
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prdata_r <= 32'h00000000;
      end else if (setup_phase & ~pwrite) begin
         if (hit_gain) begin
            prdata_r <= {24'h000000, amp_gain_setting_r};
         end else if (hit_rate) begin
            prdata_r <= {24'h000000, conv_rate_config_r};
         end else if (hit_bias) begin
            prdata_r <= {24'h000000, bias_source_config_r};
         end else begin
            prdata_r <= 32'h00000000;
         end
      end else if (setup_phase) begin
         prdata_r <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------

   // gain setting register, every code stored as written
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         amp_gain_setting_r <= `RST_AMP_GAIN_SETTING;
      end else if (wr_take & hit_gain) begin
         amp_gain_setting_r <= wbyte;
      end
   end

   // data rate register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         conv_rate_config_r <= `RST_CONV_RATE_CONFIG;
      end else if (wr_take & hit_rate) begin
         conv_rate_config_r <= wbyte;
      end
   end

   // reference control register, fields passed out raw
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bias_source_config_r <= `RST_BIAS_SOURCE_CFG;
      end else if (wr_take & hit_bias) begin
         bias_source_config_r <= wbyte;
      end
   end

   // ----------------------------------------------------------------------
   // decoded configuration outputs
   // ----------------------------------------------------------------------
   logic amp_powered_r;
   logic amp_cfg_reserved_r;
   logic [7:0] gain_mult_r;
   logic chop_enable_r;
   logic clk_src_ext_r;
   logic single_shot_r;
   logic filter_sinc3_r;
   logic [15:0] rate_sps_x10_r;
   logic rate_valid_r;
   logic [2:0] gain_code;
   logic [1:0] amp_code;
   logic [3:0] rate_code;

   assign gain_code = amp_gain_setting_r[`GAIN_MSB:`GAIN_LSB];
   assign amp_code = amp_gain_setting_r[`AMP_EN_MSB:`AMP_EN_LSB];
   assign rate_code = conv_rate_config_r[`RATE_MSB:`RATE_LSB];

   // amplifier, gain and rate decode; host keeps gain at one in bypass
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         amp_powered_r <= 1'b0;
         amp_cfg_reserved_r <= 1'b0;
         gain_mult_r <= 8'h01;
         rate_sps_x10_r <= 16'h0000;
         rate_valid_r <= 1'b0;
      end else begin
         amp_powered_r <= (amp_code == `AMP_EN_ACTIVE);
         amp_cfg_reserved_r <= amp_code[1];
         gain_mult_r <= 8'h01 << gain_code;
         rate_sps_x10_r <= rate_of(rate_code);
         rate_valid_r <= (rate_of(rate_code) != 16'h0000);
      end
   end

   // single bit mode selects
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chop_enable_r <= 1'b0;
         clk_src_ext_r <= 1'b0;
         single_shot_r <= 1'b0;
         filter_sinc3_r <= 1'b0;
      end else begin
         chop_enable_r <= conv_rate_config_r[`CHOP_BIT];
         clk_src_ext_r <= conv_rate_config_r[`CLK_SRC_BIT];
         single_shot_r <= conv_rate_config_r[`MODE_BIT];
         filter_sinc3_r <= ~conv_rate_config_r[`FILTER_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // conversion start sequencer
   // ----------------------------------------------------------------------
   adc_cfg_pkg::seq_state_t state_r;
   logic [11:0] wait_cnt_r;
   logic settle_pending_r;
   logic conv_start_r;
   logic filter_reset_r;
   logic start_now;

   // the settle wait expires on the tick that brings the count to zero,
   // unless a config change in that cycle restarts the wait
   assign start_now = (state_r == adc_cfg_pkg::SEQ_SETTLE) & mod_tick &
      (wait_cnt_r == 12'h001) & ~cfg_change;

   // a restart after a config change waits the programmed delay once
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= adc_cfg_pkg::SEQ_IDLE;
      end else begin
         case (state_r)
            adc_cfg_pkg::SEQ_IDLE: begin
               if (cfg_change & ~single_shot_r) begin
                  state_r <= adc_cfg_pkg::SEQ_SETTLE;
               end else if (start_req) begin
                  state_r <= adc_cfg_pkg::SEQ_SETTLE;
               end
            end
            adc_cfg_pkg::SEQ_SETTLE: begin
               if (start_now) begin
                  state_r <= adc_cfg_pkg::SEQ_RUN;
               end
            end
            adc_cfg_pkg::SEQ_RUN: begin
               if (cfg_change) begin
                  state_r <= adc_cfg_pkg::SEQ_SETTLE;
               end else if (conv_done & single_shot_r) begin
                  state_r <= adc_cfg_pkg::SEQ_IDLE;
               end
            end
            default: state_r <= adc_cfg_pkg::SEQ_IDLE;
         endcase
      end
   end

   // delay counter in modulator periods; a gain write uses its new code
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wait_cnt_r <= 12'h000;
      end else if (cfg_change | (start_req &
         (state_r == adc_cfg_pkg::SEQ_IDLE))) begin
         wait_cnt_r <= delay_periods((wr_take & hit_gain) ?
            wbyte[`DELAY_MSB:`DELAY_LSB] :
            amp_gain_setting_r[`DELAY_MSB:`DELAY_LSB]);
      end else if ((state_r == adc_cfg_pkg::SEQ_SETTLE) & mod_tick &
         (wait_cnt_r != 12'h000)) begin
         wait_cnt_r <= wait_cnt_r - 12'h001;
      end
   end

   // later conversions in continuous mode start without the delay
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         conv_start_r <= 1'b0;
         settle_pending_r <= 1'b0;
      end else begin
         conv_start_r <= start_now | ((state_r == adc_cfg_pkg::SEQ_RUN) &
            conv_done & ~single_shot_r & ~cfg_change);
         settle_pending_r <= (state_r == adc_cfg_pkg::SEQ_SETTLE);
      end
   end

   // one-cycle filter reset on each configuration change
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         filter_reset_r <= 1'b0;
      end else begin
         filter_reset_r <= cfg_change;
      end
   end

   // ----------------------------------------------------------------------
   // global chop: swap polarity each conversion, flag every second one
   // ----------------------------------------------------------------------
   logic chop_swap_r;
   logic chop_avg_ready_r;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chop_swap_r <= 1'b0;
         chop_avg_ready_r <= 1'b0;
      end else if (~chop_enable_r | cfg_change | settle_pending_r) begin
         chop_swap_r <= 1'b0;
         chop_avg_ready_r <= 1'b0;
      end else begin
         if (conv_done) begin
            chop_swap_r <= ~chop_swap_r;
         end
         chop_avg_ready_r <= conv_done & chop_swap_r;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign conv_start = conv_start_r;
   assign filter_reset = filter_reset_r;
   assign amp_powered = amp_powered_r;
   assign amp_cfg_reserved = amp_cfg_reserved_r;
   assign gain_mult = gain_mult_r;
   assign chop_enable = chop_enable_r;
   assign chop_swap = chop_swap_r;
   assign chop_avg_ready = chop_avg_ready_r;
   assign clk_src_ext = clk_src_ext_r;
   assign single_shot = single_shot_r;
   assign filter_sinc3 = filter_sinc3_r;
   assign rate_sps_x10 = rate_sps_x10_r;
   assign rate_valid = rate_valid_r;
   assign bias_cfg = bias_source_config_r;

endmodule

`default_nettype wire

// file: tb/adc_gain_rate_config_regs_bench.sv
// self-checking bench for the gain and rate configuration bank
`timescale 1ns/1ps
`default_nettype none
module adc_gain_rate_config_regs_bench;
   logic clk, reset_n, psel, penable, pwrite, mod_tick, start_req, conv_done;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, conv_start, filter_reset, amp_powered;
   logic amp_cfg_reserved, chop_enable, chop_swap, chop_avg_ready;
   logic clk_src_ext, single_shot, filter_sinc3, rate_valid;
   logic [7:0] gain_mult, bias_cfg;
   logic [15:0] rate_sps_x10;
   int n_mismatch = 0;
   int compares = 0;
   // rate per code in tenths of a sample per second, first-start delays
   localparam logic [255:0] rate_tab = {16'h0000, 16'h4E20, 32'h0,
      16'h2710, 16'h1F40, 16'h0FA0, 16'h07D0, 16'h03E8, 16'h0258,
      16'h01F4, 16'h00C8, 16'h00A6, 16'h0064, 16'h0032, 16'h0019};
   localparam logic [95:0] dly_tab = {12'h001, 12'h00E, 12'h800, 12'h400,
      12'h100, 12'h040, 12'h019, 12'h00E};

   adc_gain_rate_config_regs i_adc_gain_rate_config_regs (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mod_tick(mod_tick),
      .start_req(start_req), .conv_done(conv_done),
      .conv_start(conv_start), .filter_reset(filter_reset),
      .amp_powered(amp_powered), .amp_cfg_reserved(amp_cfg_reserved),
      .gain_mult(gain_mult), .chop_enable(chop_enable),
      .chop_swap(chop_swap), .chop_avg_ready(chop_avg_ready),
      .clk_src_ext(clk_src_ext), .single_shot(single_shot),
      .filter_sinc3(filter_sinc3), .rate_sps_x10(rate_sps_x10),
      .rate_valid(rate_valid), .bias_cfg(bias_cfg));

   // ---------------------------------------------------------------
   // clock, verdict and shared tasks
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic close_out();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; on a read, d is the expected byte
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [7:0] d, input logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'hFFFFA5, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         $display("FAIL %0t no ready on the bus", $time);
      end
      chk({31'h0, pslverr}, {31'h0, err});
      if (!wr) begin
         chk(prdata, {24'h0, d});
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // pulse modulator ticks until a conversion start or the limit
   task automatic ticks(input int lim, output int n);
      bit seen;
      seen = 0;
      n = 0;
      while (!seen && n <= lim) begin
         mod_tick <= 1'b1;
         @(posedge clk);
         mod_tick <= 1'b0;
         n++;
         repeat (3) begin
            @(posedge clk);
            if (conv_start === 1'b1) seen = 1;
         end
      end
   endtask

   task automatic pulse_done();
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      @(posedge clk);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      apb(1'b0, 8'h0C, 8'h00, 1'b0);
      apb(1'b0, 8'h10, 8'h14, 1'b0);
      apb(1'b0, 8'h14, 8'h10, 1'b0);
      chk({gain_mult, rate_sps_x10, bias_cfg}, 32'h0100C810);
      chk({26'h0, amp_powered, chop_enable, clk_src_ext, single_shot,
         filter_sinc3, rate_valid}, 32'h1);
      apb(1'b1, 8'h18, 8'hFF, 1'b1);
      apb(1'b0, 8'h00, 8'h00, 1'b1);
      apb(1'b1, 8'h14, 8'hC3, 1'b0);
      apb(1'b0, 8'h14, 8'hC3, 1'b0);
   endtask

   task automatic t_gain();
      logic [7:0] v;
      for (int c = 0; c < 8; c++) begin
         v = {3'b000, 2'b01, c[2:0]};
         apb(1'b1, 8'h0C, v, 1'b0);
         apb(1'b0, 8'h0C, v, 1'b0);
         chk({24'h0, gain_mult}, 32'h1 << c);
      end
      for (int a = 3; a >= 0; a--) begin
         v = {3'b000, a[1:0], 3'b000};
         apb(1'b1, 8'h0C, v, 1'b0);
         apb(1'b0, 8'h0C, v, 1'b0);
         chk({30'h0, amp_powered, amp_cfg_reserved},
            {30'h0, a == 1, a[1]});
      end
   endtask

   task automatic t_rate();
      logic [7:0] v;
      for (int c = 0; c < 16; c++) begin
         v = {c[3:0], c[3:0]};
         apb(1'b1, 8'h10, v, 1'b0);
         apb(1'b0, 8'h10, v, 1'b0);
         chk({chop_enable, clk_src_ext,
            single_shot, filter_sinc3}, {c[3:1], !c[0]});
         chk({16'h0, rate_sps_x10}, {16'h0, rate_tab[c * 16 +: 16]});
         chk({31'h0, rate_valid},
            {31'h0, rate_tab[c * 16 +: 16] != 0});
      end
      apb(1'b1, 8'h10, 8'h14, 1'b0);
   endtask

   task automatic t_delay();
      int n;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, 8'h0C, {c[2:0], 5'b01000}, 1'b0);
         chk({31'h0, filter_reset}, 32'h1);
         ticks(2100, n);
         chk(n, {20'h0, dly_tab[c * 12 +: 12]});
      end
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      @(posedge clk);
      chk({31'h0, conv_start}, 32'h1);
      apb(1'b1, 8'h0C, 8'hE8, 1'b0);
      chk({31'h0, filter_reset}, 32'h0);
      ticks(3, n);
      chk(n, 4);
   endtask

   task automatic t_chop_single();
      int n;
      logic s;
      apb(1'b1, 8'h10, 8'h94, 1'b0);
      ticks(3, n);
      chk(n, 1);
      s = chop_swap;
      for (int k = 0; k < 2; k++) begin
         pulse_done();
         chk({30'h0, chop_swap, chop_avg_ready},
            {30'h0, s ^ (k == 0), k == 1});
      end
      apb(1'b1, 8'h10, 8'h34, 1'b0);
      ticks(3, n);
      chk(n, 1);
      pulse_done();
      chk({31'h0, conv_start}, 32'h0);
      ticks(3, n);
      chk(n, 4);
      start_req <= 1'b1;
      @(posedge clk);
      start_req <= 1'b0;
      ticks(3, n);
      chk(n, 1);
   endtask

   // watchdog against a hang
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      $display("FAIL %0t watchdog expired", $time);
      close_out();
   end

   // main sequence
   initial begin
      reset_n = 1'b0;
      {psel, penable, pwrite, mod_tick, start_req, conv_done} = '0;
      paddr = '0;
      pwdata = '0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_gain();
      t_rate();
      t_delay();
      t_chop_single();
      close_out();
   end
endmodule

bind adc_gain_rate_config_regs adc_cfg_monitor i_adc_cfg_monitor (
   .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
   .filter_reset(filter_reset), .amp_powered(amp_powered),
   .amp_cfg_reserved(amp_cfg_reserved), .gain_mult(gain_mult),
   .chop_enable(chop_enable), .clk_src_ext(clk_src_ext),
   .single_shot(single_shot), .filter_sinc3(filter_sinc3),
   .rate_sps_x10(rate_sps_x10), .rate_valid(rate_valid),
   .bias_cfg(bias_cfg));
`default_nettype wire

// file: tb/adc_gain_rate_config_regs_monitor.sv
// assertion checker for the gain and rate configuration bank
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_start,
   input wire logic filter_reset,
   input wire logic amp_powered,
   input wire logic amp_cfg_reserved,
   input wire logic [7:0] gain_mult,
   input wire logic chop_enable,
   input wire logic clk_src_ext,
   input wire logic single_shot,
   input wire logic filter_sinc3,
   input wire logic [15:0] rate_sps_x10,
   input wire logic rate_valid,
   input wire logic [7:0] bias_cfg
);
   // ---------------------------------------------------------------
   // rate table in tenths of a sample per second, code 0 lowest
   // ---------------------------------------------------------------
   localparam logic [255:0] rate_tab = {16'h0000, 16'h4E20, 32'h0,
      16'h2710, 16'h1F40, 16'h0FA0, 16'h07D0, 16'h03E8, 16'h0258,
      16'h01F4, 16'h00C8, 16'h00A6, 16'h0064, 16'h0032, 16'h0019};
   logic wr_acc;
   // completed write transfer
   assign wr_acc = psel && penable && pwrite && pready;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_ready_timing;
      psel && !penable |=> pready;
   endproperty
   a_ready_timing: assert property (p_ready_timing)
      else $error("ready missing one cycle after setup");
   property p_ready_cause;
      pready |-> $past(psel) && !$past(penable);
   endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready without a setup cycle before");
   property p_err_decode;
      pready |-> pslverr == !(paddr inside {8'h0C, 8'h10, 8'h14});
   endproperty
   a_err_decode: assert property (p_err_decode)
      else $error("error flag does not match address map");
   property p_rdata_clean;
      pready |-> prdata[31:8] == 24'h0 && (!pslverr || pwrite || prdata == 0);
   endproperty
   a_rdata_clean: assert property (p_rdata_clean)
      else $error("read data has stray bits");
   property p_gain_decode;
      logic [7:0] d;
      (wr_acc && paddr == 8'h0C, d = pwdata[7:0]) |-> ##2
         gain_mult == (8'h01 << d[2:0]) && amp_cfg_reserved == d[4]
         && amp_powered == (d[4:3] == 2'b01);
   endproperty
   a_gain_decode: assert property (p_gain_decode)
      else $error("gain or amplifier decode wrong after write");
   property p_rate_decode;
      logic [7:0] d;
      (wr_acc && paddr == 8'h10, d = pwdata[7:0]) |-> ##2
         {chop_enable, clk_src_ext, single_shot, filter_sinc3} ==
         {d[7:5], !d[4]} && rate_sps_x10 == rate_tab[d[3:0] * 16 +: 16]
         && rate_valid == (rate_tab[d[3:0] * 16 +: 16] != 16'h0);
   endproperty
   a_rate_decode: assert property (p_rate_decode)
      else $error("rate register decode wrong after write");
   property p_bias_copy;
      logic [7:0] d;
      (wr_acc && paddr == 8'h14, d = pwdata[7:0]) |-> ##2 bias_cfg == d;
   endproperty
   a_bias_copy: assert property (p_bias_copy)
      else $error("reference register output wrong after write");
   property p_start_pulse;
      conv_start |=> !conv_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("conversion start longer than one cycle");
   property p_filter_cause;
      filter_reset |-> $past(wr_acc) ##1 !filter_reset;
   endproperty
   a_filter_cause: assert property (p_filter_cause)
      else $error("filter reset without a write before it");
endmodule
`default_nettype wire
